// [hw/torque_off_loss_supervision.v]
// Torque-off channel loss supervisor with cabling/ground fault selector
`timescale 1ns/1ps
`default_nettype none
`include "torque_off_sup_map.vh"

// Functional notes
// RULE1 - Code 1: any channel loss latches the trip fault, run state ignored.
// RULE2 - Codes 2 and 3 while running: any channel loss latches the trip fault.
// RULE3 - Both channels absent: alarm under code 2 stopped, code 4 always.
// RULE4 - One channel lost: per-channel fault under 2/3 stopped, 4 always.
// RULE5 - Code 3 stopped with both channels absent: no alarm, no fault.
// RULE6 - Reaction code only affects reporting; torque disable follows channels.
// RULE7 - Externally powered control without main power masks per-channel faults.
// RULE8 - Cabling/ground fault ignored at 0, latches cabling fault at 1.
// RULE9 - Configurer should select no action when fed through DC link.
// RULE10 - Faults latch until fault reset; alarm follows the live condition.
module torque_off_loss_supervision (
  // Clock and reset
  input wire ref_clk_i,
  input wire arst_n_i,
  // Channel pins, active high means channel present
  input wire chan1_present_i,
  input wire chan2_present_i,
  // Drive state pins
  input wire running_i,
  input wire ext_ctrl_power_only_i,
  input wire cabling_ground_detect_i,
  // Settings and fault reset from control logic
  input wire [2:0] channel_loss_reaction_i,
  input wire cabling_fault_reaction_i,
  input wire fault_reset_i,
  // Outputs
  output reg torque_disable_o,
  output reg torque_disable_trip_fault_o,
  output reg torque_disable_trip_alarm_o,
  output reg first_channel_lost_fault_o,
  output reg second_channel_lost_fault_o,
  output reg cabling_ground_fault_o
);

  // Pins come from another domain: two flops each before any logic
  localparam PIN_CNT = 5;
  localparam PIN_CHAN1 = 0;
  localparam PIN_CHAN2 = 1;
  localparam PIN_RUN = 2;
  localparam PIN_EXT = 3;
  localparam PIN_CAB = 4;

  wire [PIN_CNT-1:0] pin_raw;
  wire [PIN_CNT-1:0] pin_sync;

  assign pin_raw[PIN_CHAN1] = chan1_present_i;
  assign pin_raw[PIN_CHAN2] = chan2_present_i;
  assign pin_raw[PIN_RUN] = running_i;
  assign pin_raw[PIN_EXT] = ext_ctrl_power_only_i;
  assign pin_raw[PIN_CAB] = cabling_ground_detect_i;

  genvar g;
  generate
    for (g = 0; g < PIN_CNT; g = g + 1) begin : g_pin_sync
      reg meta_r;
      reg stable_r;
      always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_r <= `PIN_RESET;
          stable_r <= `PIN_RESET;
        end else begin
          meta_r <= pin_raw[g];
          stable_r <= meta_r;
        end
      end
      // Only the second flop feeds logic
      assign pin_sync[g] = stable_r;
    end
  endgenerate

  // Reset value reads as channels lost, so disable holds until pins settle
  wire lost1 = ~pin_sync[PIN_CHAN1];
  wire lost2 = ~pin_sync[PIN_CHAN2];
  wire run = pin_sync[PIN_RUN];
  wire ext_only = pin_sync[PIN_EXT];
  wire cab_det = pin_sync[PIN_CAB];
  wire any_lost = lost1 | lost2;
  wire both_lost = lost1 & lost2;
  wire one_lost = lost1 ^ lost2;
  // Code is a same-clock setting, used without synchronising
  wire [2:0] code = channel_loss_reaction_i;

  // Trip on any loss: code 1 always, codes 2 and 3 only while running
  function trip_on_loss;
    input [2:0] c;
    input r;
    begin
      case (c)
        `REACT_FAULT: trip_on_loss = 1'h1; // [RULE1]
        `REACT_ALARM: trip_on_loss = r; // [RULE2]
        `REACT_NONE: trip_on_loss = r; // [RULE2]
        default: trip_on_loss = 1'h0;
      endcase
    end
  endfunction

  // Alarm on both absent: code 2 stopped, code 4 always
  function alarm_on_both;
    input [2:0] c;
    input r;
    begin
      case (c)
        `REACT_ALARM: alarm_on_both = ~r; // [RULE3]
        `REACT_NONE: alarm_on_both = 1'h0; // [RULE5]
        `REACT_ONLY_ALARM: alarm_on_both = 1'h1; // [RULE3]
        default: alarm_on_both = 1'h0;
      endcase
    end
  endfunction

  // Per-channel fault on one lost: codes 2 and 3 stopped, code 4 always
  function single_on_one;
    input [2:0] c;
    input r;
    begin
      case (c)
        `REACT_ALARM: single_on_one = ~r; // [RULE4]
        `REACT_NONE: single_on_one = ~r; // [RULE4]
        `REACT_ONLY_ALARM: single_on_one = 1'h1; // [RULE4]
        default: single_on_one = 1'h0;
      endcase
    end
  endfunction

  // Sticky flag update
  function sticky;
    input set_now;
    input held_now;
    input clear_now;
    begin
      // A live cause beats a reset in the same cycle
      sticky = set_now | (held_now & ~clear_now);
    end
  endfunction

  reg trip_set;
  reg alarm_nxt;
  reg single_set;
  always @* begin
    trip_set = 1'h0;
    alarm_nxt = 1'h0;
    single_set = 1'h0;
    trip_set = trip_on_loss(code, run) & any_lost; // [RULE1] [RULE2]
    alarm_nxt = alarm_on_both(code, run) & both_lost; // [RULE3] [RULE5]
    single_set = single_on_one(code, run) & one_lost; // [RULE4]
  end

  wire cab_set = (cabling_fault_reaction_i == `CABLING_TRIP) & cab_det; // [RULE8]
  wire s1_set = single_set & lost1 & ~ext_only; // [RULE7]
  wire s2_set = single_set & lost2 & ~ext_only; // [RULE7]

  // Torque disable ignores the reaction code entirely
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      torque_disable_o <= `DISABLE_RESET;
    end else begin
      torque_disable_o <= any_lost; // [RULE6]
    end
  end

  // Alarm follows the live condition, no latch
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      torque_disable_trip_alarm_o <= `FLAG_RESET;
    end else begin
      torque_disable_trip_alarm_o <= alarm_nxt; // [RULE10]
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      torque_disable_trip_fault_o <= `FLAG_RESET;
    end else begin
      torque_disable_trip_fault_o <= sticky(trip_set, torque_disable_trip_fault_o,
        fault_reset_i); // [RULE10]
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      first_channel_lost_fault_o <= `FLAG_RESET;
    end else begin
      first_channel_lost_fault_o <= sticky(s1_set, first_channel_lost_fault_o,
        fault_reset_i); // [RULE10]
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      second_channel_lost_fault_o <= `FLAG_RESET;
    end else begin
      second_channel_lost_fault_o <= sticky(s2_set, second_channel_lost_fault_o,
        fault_reset_i); // [RULE10]
    end
  end

  // DC-link feeding needs this left at no action, else nuisance trips
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cabling_ground_fault_o <= `FLAG_RESET;
    end else begin
      cabling_ground_fault_o <= sticky(cab_set, cabling_ground_fault_o,
        fault_reset_i); // [RULE8]
    end
  end

endmodule // torque_off_loss_supervision
`default_nettype wire

// [hw/torque_off_sup_map.vh]
// Codes and reset values for the torque-off loss supervisor
`ifndef TORQUE_OFF_SUP_MAP_VH
`define TORQUE_OFF_SUP_MAP_VH
`define REACT_FAULT 3'h1
`define REACT_ALARM 3'h2
`define REACT_NONE 3'h3
`define REACT_ONLY_ALARM 3'h4
`define CABLING_NO_ACTION 1'h0
`define CABLING_TRIP 1'h1
`define REACT_RESET 3'h1
`define FLAG_RESET 1'h0
`define PIN_RESET 1'h0
`define DISABLE_RESET 1'h1
`endif

// [sim/safety_circuit_model.sv]
// Far-side safety circuit driving both channels
`timescale 1ns/1ps
`default_nettype none
module safety_circuit_model (input wire logic [1:0] keep_i, output logic [1:0] chan_o);
  assign chan_o = keep_i; // Plain level source, no debounce
endmodule // safety_circuit_model
`default_nettype wire

// [sim/torque_off_loss_supervision_properties.sv]
// Assertions for the torque-off loss supervisor
`timescale 1ns/1ps
`default_nettype none
module tol_props (
  input wire logic ref_clk_i, arst_n_i, chan1_present_i, chan2_present_i, running_i,
  input wire logic ext_ctrl_power_only_i, cabling_ground_detect_i, cabling_fault_reaction_i,
  input wire logic fault_reset_i, torque_disable_o, torque_disable_trip_fault_o,
  input wire logic torque_disable_trip_alarm_o, first_channel_lost_fault_o, cabling_ground_fault_o,
  input wire logic second_channel_lost_fault_o,
  input wire logic [2:0] channel_loss_reaction_i
);
  wire [2:0] r = channel_loss_reaction_i;
  wire l1 = !chan1_present_i;
  wire l2 = !chan2_present_i;
  wire tf = torque_disable_trip_fault_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Five samples cover the two-stage pin synchroniser
  sequence held(b); b [*5]; endsequence
  chk_td_follow: assert property (held(l1 || l2) |-> torque_disable_o)
    else $error("torque not disabled");
  chk_code1_trip: assert property (held(l1 && r == 3'h1) |-> tf)
    else $error("no trip at code 1");
  chk_run_trip: assert property (held(l2 && running_i && r == 3'h2) |-> tf)
    else $error("no trip while running");
  chk_both_alarm: assert property (held(l1 && l2 && r == 3'h4) |-> torque_disable_trip_alarm_o)
    else $error("no alarm");
  chk_one_lost: assert property (held(l1 && !l2 && !ext_ctrl_power_only_i && r == 3'h4) |->
    first_channel_lost_fault_o) else $error("no channel fault");
  chk_two_lost: assert property (held(l2 && !l1 && !ext_ctrl_power_only_i && r == 3'h4) |->
    second_channel_lost_fault_o) else $error("no second channel fault");
  chk_quiet_stop: assert property (held(l1 && l2 && !running_i && r == 3'h3 && fault_reset_i) |->
    !tf && !torque_disable_trip_alarm_o) else $error("report at code 3");
  chk_ext_mask: assert property (held(ext_ctrl_power_only_i && fault_reset_i) |->
    !first_channel_lost_fault_o) else $error("channel fault not masked");
  chk_cable_trip: assert property (held(cabling_ground_detect_i && cabling_fault_reaction_i) |->
    cabling_ground_fault_o) else $error("no cabling fault");
  chk_fault_hold: assert property (tf && !fault_reset_i |=> tf)
    else $error("fault not latched");
endmodule // tol_props
bind torque_off_loss_supervision tol_props chk (.*);
`default_nettype wire

// [sim/torque_off_loss_supervision_test.sv]
// Bench for the torque-off loss supervisor
`timescale 1ns/1ps
`default_nettype none
module torque_off_loss_supervision_test;
  logic ref_clk_i = 0, arst_n_i = 0, running_i = 0, ext_ctrl_power_only_i = 0;
  logic fault_reset_i = 0, cabling_ground_detect_i = 0, cabling_fault_reaction_i = 0;
  logic [2:0] channel_loss_reaction_i = 3'h0;
  logic [1:0] keep = 2'h3;
  wire chan1_present_i, chan2_present_i, torque_disable_o, torque_disable_trip_fault_o;
  wire torque_disable_trip_alarm_o, first_channel_lost_fault_o;
  wire second_channel_lost_fault_o, cabling_ground_fault_o;
  wire [3:0] seen = {torque_disable_o, torque_disable_trip_fault_o,
    torque_disable_trip_alarm_o, first_channel_lost_fault_o};
  wire [1:0] lc = {first_channel_lost_fault_o, cabling_ground_fault_o};
  int error_cnt = 0, total_checks = 0;
  // Code, run, channels, then expected disable, trip, alarm, first fault
  logic [9:0] rows [7] = '{10'h0AC, 10'h15C, 10'h10A, 10'h24A, 10'h1A9, 10'h188, 10'h028};
  initial forever #2 ref_clk_i = ~ref_clk_i;
  safety_circuit_model far (.keep_i(keep), .chan_o({chan2_present_i, chan1_present_i}));
  torque_off_loss_supervision DUT (.*);
  task chk(string n, logic [3:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task print_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Six cycles clear the pin latency with margin
  task hold(logic v);
    fault_reset_i = v;
    repeat (6) @(negedge ref_clk_i);
  endtask
  initial begin
    repeat (3) @(negedge ref_clk_i);
    chk("reset", 4'h8, seen);
    arst_n_i = 1;
    foreach (rows[i]) begin
      {channel_loss_reaction_i, running_i, keep} = rows[i][9:4];
      hold(1);
      hold(0);
      chk("row", rows[i][3:0], seen);
    end
    {channel_loss_reaction_i, keep, ext_ctrl_power_only_i, cabling_ground_detect_i} = 7'h4B;
    hold(1);
    chk("masked", 4'h0, lc);
    {ext_ctrl_power_only_i, cabling_fault_reaction_i} = 2'h1;
    hold(0);
    {keep, cabling_ground_detect_i} = 3'h6;
    hold(0);
    chk("latched", 4'h3, lc);
    hold(1);
    chk("cleared", 4'h0, {lc, second_channel_lost_fault_o});
    keep = 2'h1;
    hold(0);
    chk("second", 4'h1, second_channel_lost_fault_o);
    arst_n_i = 0;
    @(negedge ref_clk_i);
    chk("midreset", 4'h8, {seen[3:1], second_channel_lost_fault_o});
    arst_n_i = 1;
    hold(0);
    chk("rerun", 4'h1, second_channel_lost_fault_o);
    print_verdict;
  end
endmodule // torque_off_loss_supervision_test
`default_nettype wire
